// >>> acs_afe_model.sv
`timescale 1ns/10ps
module acs_afe_model #(
    parameter int RES_BITS = 8
) (
    // clock
    input  wire logic              sys_clk,
    // bench control
    input  wire logic              rc_en,
    input  wire logic [15:0]       target,
    // front end drive and answers
    input  wire acs_pkg::acs_afe_s afe,
    output logic                   rc_osc_pin,
    output logic                   cmp_pin
);
    import acs_pkg::*;

    logic idle_ff = 1'b0;

    // rc clock runs only while enabled, unrelated in phase to sys_clk
    initial
    begin
        rc_osc_pin = 1'b0;
        forever
        begin
            #117;
            rc_osc_pin = rc_en ? ~rc_osc_pin : 1'b0;
        end
    end

    // comparator keeps trial bit while code is not above target; toggles when unused
    always @(posedge sys_clk)
    begin
        idle_ff <= ~idle_ff;
    end
    assign cmp_pin = afe.convert ? (afe.dac_code[RES_BITS-1:0] <= target[RES_BITS-1:0])
                                 : idle_ff;
endmodule : acs_afe_model

// >>> acs_conv_seq.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "acs_defines.svh"

module acs_conv_seq #(
    parameter int RES_BITS = 12
) (
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset,
    // register port
    input  wire acs_pkg::acs_bus_s bus,
    output logic [7:0]           reg_rdata,
    // analog front end
    input  wire logic            rc_osc_pin,
    input  wire logic            cmp_pin,
    output acs_pkg::acs_afe_s    afe,
    // neighbouring computation logic
    input  wire logic            threshold_irq_flag,
    output logic                 compute_start,
    // interrupt
    output logic                 irq
);
    import acs_pkg::*;

    generate
        if (RES_BITS < 2 || RES_BITS > 16)
        begin : g_bad_res
            $error("RES_BITS must lie between 2 and 16");
        end
    endgenerate

    acs_state_s q;
    acs_state_s n;

    logic        wr_con0;
    logic        start_req;
    logic        abort_req;
    logic        conv_last;
    logic [12:0] acq_len;
    logic [15:0] bit_m;

    function automatic logic [15:0] fmt(input logic [15:0] v, input logic right);
        if (right)
            return v;
        return v << (16 - RES_BITS);
    endfunction : fmt

    assign wr_con0   = bus.wr && bus.addr == `ACS_ADR_CON0;
    assign start_req = wr_con0 && bus.wdata[`ACS_GO_BIT] && bus.wdata[`ACS_ON_BIT] && !q.go;
    assign abort_req = wr_con0 && q.go
                       && !(bus.wdata[`ACS_GO_BIT] && bus.wdata[`ACS_ON_BIT]);
    assign conv_last = q.st == ST_CONV && q.tick && q.bitpos == 4'h0;
    assign acq_len   = (q.acq != 13'h0000) ? q.acq
                     : (q.pre != 13'h0000) ? `ACS_ACQ_DEFAULT : 13'h0000;
    assign bit_m     = 16'h0001 << q.bitpos;

    always_comb
    begin
        logic launch;
        logic enter_conv;
        logic [15:0] final_v;
        logic flip;
        launch     = 1'b0;
        flip       = 1'b0;
        enter_conv = 1'b0;
        final_v    = q.cmp_s2 ? q.code : (q.code & ~bit_m);
        n          = q;
        n.tick     = 1'b0;
        n.compute  = 1'b0;
        n.rdata    = 8'h00;

        // pin synchronisers
        n.rc_s1  = rc_osc_pin;
        n.rc_s2  = q.rc_s1;
        n.rc_s3  = q.rc_s2;
        n.cmp_s1 = cmp_pin;
        n.cmp_s2 = q.cmp_s1;

        // converter clock tick
        if (q.cs)
        begin
            n.tick   = q.rc_s2 && !q.rc_s3;
            n.divcnt = 8'h00;
        end
        else if (q.divcnt >= q.div)
        begin
            n.tick   = 1'b1;
            n.divcnt = 8'h00;
        end
        else
        begin
            n.divcnt = q.divcnt + 8'h01;
        end

        // register writes
        if (bus.wr)
        begin
            case (bus.addr)
                `ACS_ADR_ACQ_LO:  n.acq[7:0]  = bus.wdata;
                `ACS_ADR_ACQ_HI:  n.acq[12:8] = bus.wdata[4:0];
                `ACS_ADR_CAP:     n.cap       = bus.wdata[4:0];
                `ACS_ADR_PRE_LO:  n.pre[7:0]  = bus.wdata;
                `ACS_ADR_PRE_HI:  n.pre[12:8] = bus.wdata[4:0];
                `ACS_ADR_CON0:
                begin
                    n.on   = bus.wdata[`ACS_ON_BIT];
                    n.continuous_enable = bus.wdata[`ACS_CONTINUOUS_ENABLE_BIT];
                    n.cs   = bus.wdata[`ACS_CS_BIT];
                    n.result_alignment  = bus.wdata[`ACS_FRM_BIT];
                end
                `ACS_ADR_CON1:
                begin
                    n.precharge_polarity = bus.wdata[`ACS_PRECHARGE_POLARITY_BIT];
                    n.invert_precharge_enable = bus.wdata[`ACS_INVERT_PRECHARGE_ENABLE_BIT];
                    n.guard_polarity = bus.wdata[`ACS_GUARD_POLARITY_BIT];
                    n.double_sample_enable = bus.wdata[`ACS_DOUBLE_SAMPLE_ENABLE_BIT];
                end
                `ACS_ADR_DIV:     n.div       = bus.wdata;
                `ACS_ADR_STAT:    n.status    = q.status & ~bus.wdata[1:0];
                `ACS_ADR_MASK:    n.mask      = bus.wdata[1:0];
                `ACS_ADR_CON3:    n.stop_on_irq       = bus.wdata[`ACS_SOI_BIT];
                default:          n.mask      = n.mask;
            endcase
        end

        // threshold event and continuous stop request
        if (threshold_irq_flag)
            n.status[`ACS_EV_THR_BIT] = 1'b1;
        if (q.go && q.continuous_enable && q.stop_on_irq && threshold_irq_flag)
            n.stop_req = 1'b1;

        // sequencer
        if (abort_req)
        begin
            n.res    = fmt(q.code & ~bit_m, q.result_alignment);
            n.st     = ST_IDLE;
            n.go     = 1'b0;
            n.second = 1'b0;
            n.code   = 16'h0000;
        end
        else if (start_req)
        begin
            n.go       = 1'b1;
            n.second   = 1'b0;
            n.stop_req = 1'b0;
            if (!q.double_sample_enable)
                n.prev = q.res;
            launch     = 1'b1;
        end
        else if (q.tick)
        begin
            case (q.st)
                ST_PRE:
                begin
                    n.cnt = q.cnt + 13'd1;
                    if (q.cnt == q.pre - 13'd1)
                    begin
                        n.cnt = 13'h0000;
                        if (acq_len != 13'h0000)
                            n.st = ST_ACQ;
                        else
                            enter_conv = 1'b1;
                    end
                end
                ST_ACQ:
                begin
                    n.cnt = q.cnt + 13'd1;
                    if (q.cnt == acq_len - 13'd1)
                        enter_conv = 1'b1;
                end
                ST_CONV:
                begin
                    n.code = final_v;
                    if (q.bitpos != 4'h0)
                    begin
                        n.bitpos = q.bitpos - 4'h1;
                        n.code   = final_v | (bit_m >> 1);
                    end
                    else if (q.double_sample_enable && !q.second)
                    begin
                        n.prev   = fmt(final_v, q.result_alignment);
                        n.second = 1'b1;
                        launch   = 1'b1;
                    end
                    else
                    begin
                        n.res     = fmt(final_v, q.result_alignment);
                        n.status[`ACS_EV_DONE_BIT] = 1'b1;
                        n.compute = 1'b1;
                        n.second  = 1'b0;
                        if (q.continuous_enable && !(q.stop_on_irq && (q.stop_req || threshold_irq_flag)))
                        begin
                            if (!q.double_sample_enable)
                                n.prev = fmt(final_v, q.result_alignment);
                            launch = 1'b1;
                        end
                        else
                        begin
                            n.go   = 1'b0;
                            n.st   = ST_IDLE;
                            n.code = 16'h0000;
                        end
                    end
                end
                default:
                    n.cnt = 13'h0000;
            endcase
        end

        if (launch)
        begin
            n.cnt = 13'h0000;
            if (q.pre != 13'h0000)
                n.st = ST_PRE;
            else if (acq_len != 13'h0000)
                n.st = ST_ACQ;
            else
                enter_conv = 1'b1;
        end
        if (enter_conv)
        begin
            n.st     = ST_CONV;
            n.cnt    = 13'h0000;
            n.bitpos = 4'(RES_BITS - 1);
            n.code   = 16'h0001 << (RES_BITS - 1);
        end

        // register reads
        if (bus.rd)
        begin
            case (bus.addr)
                `ACS_ADR_ACQ_LO:  n.rdata = q.acq[7:0];
                `ACS_ADR_ACQ_HI:  n.rdata = {3'h0, q.acq[12:8]};
                `ACS_ADR_CAP:     n.rdata = {3'h0, q.cap};
                `ACS_ADR_PRE_LO:  n.rdata = q.pre[7:0];
                `ACS_ADR_PRE_HI:  n.rdata = {3'h0, q.pre[12:8]};
                `ACS_ADR_CON0:    n.rdata = {q.on, q.continuous_enable, 1'b0, q.cs, 1'b0, q.result_alignment, 1'b0, q.go};
                `ACS_ADR_CON1:    n.rdata = {q.precharge_polarity, q.invert_precharge_enable, q.guard_polarity, 4'h0, q.double_sample_enable};
                `ACS_ADR_DIV:     n.rdata = q.div;
                `ACS_ADR_STAT:    n.rdata = {6'h00, q.status};
                `ACS_ADR_MASK:    n.rdata = {6'h00, q.mask};
                `ACS_ADR_RES_LO:  n.rdata = q.res[7:0];
                `ACS_ADR_RES_HI:  n.rdata = q.res[15:8];
                `ACS_ADR_PREV_LO: n.rdata = q.prev[7:0];
                `ACS_ADR_PREV_HI: n.rdata = q.prev[15:8];
                `ACS_ADR_CON3:    n.rdata = {7'h00, q.stop_on_irq};
                default:          n.rdata = 8'h00;
            endcase
        end

        // interrupt and front end drive
        n.irq             = |(n.status & n.mask);
        n.afe.extra_cap   = n.cap;
        n.afe.precharge   = n.st == ST_PRE;
        flip              = n.double_sample_enable && n.invert_precharge_enable && n.second;
        n.afe.pre_level   = n.precharge_polarity ^ flip;
        n.afe.guard_level = n.guard_polarity ^ flip;
        n.afe.acquire     = n.st == ST_ACQ;
        n.afe.convert     = n.st == ST_CONV;
        n.afe.dac_code    = n.code;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            q     <= '0;
            q.st  <= ST_IDLE;
        end
        else
        begin
            q <= n;
        end
    end

    assign reg_rdata     = q.rdata;
    assign afe           = q.afe;
    assign compute_start = q.compute;
    assign irq           = q.irq;

    // helper counters for phase lengths
    logic [12:0] pre_seen;
    logic [12:0] acq_seen;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pre_seen <= 13'h0000;
            acq_seen <= 13'h0000;
        end
        else
        begin
            pre_seen <= (q.st == ST_PRE && n.st == ST_PRE) ? pre_seen + 13'(q.tick) : 13'h0000;
            acq_seen <= (q.st == ST_ACQ && n.st == ST_ACQ) ? acq_seen + 13'(q.tick) : 13'h0000;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_cap_drive: assert property (
        bus.wr && bus.addr == `ACS_ADR_CAP |=> afe.extra_cap == $past(bus.wdata[4:0]))
        else $error("extra capacitance not following field");
    a_pre_length: assert property (
        q.st == ST_PRE && n.st != ST_PRE && !abort_req |-> pre_seen == q.pre - 13'd1)
        else $error("precharge phase length wrong");
    a_pre_skip: assert property (
        start_req && q.pre == 13'h0000 |=> !afe.precharge)
        else $error("precharge phase not skipped");
    a_acq_default: assert property (
        q.st == ST_ACQ && n.st != ST_ACQ && !abort_req && q.acq == 13'h0000
        |-> acq_seen == 13'd255)
        else $error("default acquisition length wrong");
    a_go_needs_on: assert property (
        wr_con0 && !bus.wdata[`ACS_ON_BIT] |=> !q.go)
        else $error("start bit set without enable");
    a_go_busy: assert property (
        q.go == (q.st != ST_IDLE))
        else $error("start bit disagrees with sequencer");
    a_single_stop: assert property (
        conv_last && !abort_req && !q.continuous_enable && !(q.double_sample_enable && !q.second) |=> !q.go ##1 !q.go)
        else $error("start bit not cleared at completion");
    a_abort_quiet: assert property (
        abort_req |=> q.st == ST_IDLE && !compute_start
                      && q.status[`ACS_EV_DONE_BIT] == $past(q.status[`ACS_EV_DONE_BIT]))
        else $error("abort raised flag or left sequencer running");
    a_pre_invert: assert property (
        afe.precharge && q.double_sample_enable && q.invert_precharge_enable && q.second |-> afe.pre_level == !q.precharge_polarity)
        else $error("second precharge not inverted");
    a_pre_polarity: assert property (
        afe.precharge && !q.second |-> afe.pre_level == q.precharge_polarity)
        else $error("first precharge level wrong");
    a_same_polarity: assert property (
        afe.precharge && !q.invert_precharge_enable |-> afe.pre_level == q.precharge_polarity && afe.guard_level == q.guard_polarity)
        else $error("polarity changed without inversion");
    a_guard_level: assert property (
        afe.precharge && !q.second |-> afe.guard_level == q.guard_polarity)
        else $error("guard start level wrong");
    a_phase_order: assert property (
        $rose(afe.convert) |-> $past(afe.acquire) || $past(acq_len == 13'h0000))
        else $error("conversion entered out of order");
    a_left_fill: assert property (
        compute_start && !$past(q.result_alignment) |-> (q.res << RES_BITS) == 16'h0000)
        else $error("left justified result not zero filled");
    a_right_just: assert property (
        compute_start && $past(q.result_alignment) |-> (q.res >> RES_BITS) == 16'h0000)
        else $error("right justified result has high bits");
    a_continuous_enable_retrig: assert property (
        conv_last && !abort_req && q.continuous_enable && !q.stop_on_irq && !(q.double_sample_enable && !q.second) |=> q.go)
        else $error("continuous mode did not retrigger");
    a_rc_tick: assert property (
        q.cs && !(q.rc_s2 && !q.rc_s3) |=> !q.tick)
        else $error("tick without oscillator edge");
    a_pre_hi_read: assert property (
        bus.rd && bus.addr == `ACS_ADR_PRE_HI |=> reg_rdata[7:5] == 3'h0)
        else $error("precharge high byte upper bits set");

    c_complete: cover property (compute_start);
    c_abort:    cover property (abort_req && q.st == ST_CONV);
    c_double:   cover property (q.second && afe.convert);
    c_continuous_enable:     cover property (compute_start && q.go);
    c_rc:       cover property (q.cs && afe.convert);

endmodule : acs_conv_seq

// >>> acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// register byte addresses
`define ACS_ADR_ACQ_LO   9'h10C
`define ACS_ADR_ACQ_HI   9'h10D
`define ACS_ADR_CAP      9'h10E
`define ACS_ADR_PRE_LO   9'h10F
`define ACS_ADR_PRE_HI   9'h110
`define ACS_ADR_CON0     9'h111
`define ACS_ADR_CON1     9'h112
`define ACS_ADR_DIV      9'h118
`define ACS_ADR_STAT     9'h119
`define ACS_ADR_MASK     9'h11A
`define ACS_ADR_RES_LO   9'h11B
`define ACS_ADR_RES_HI   9'h11C
`define ACS_ADR_PREV_LO  9'h11D
`define ACS_ADR_PREV_HI  9'h11E
`define ACS_ADR_CON3     9'h11F

// control zero fields
`define ACS_ON_BIT       7
`define ACS_CONTINUOUS_ENABLE_BIT     6
`define ACS_CS_BIT       4
`define ACS_FRM_BIT      2
`define ACS_GO_BIT       0
// control one fields
`define ACS_PRECHARGE_POLARITY_BIT     7
`define ACS_INVERT_PRECHARGE_ENABLE_BIT     6
`define ACS_GUARD_POLARITY_BIT     5
`define ACS_DOUBLE_SAMPLE_ENABLE_BIT     0
// control three / status fields
`define ACS_SOI_BIT      0
`define ACS_EV_DONE_BIT  0
`define ACS_EV_THR_BIT   1

// reset values
`define ACS_RST_BYTE     8'h00
`define ACS_RST_DIV      8'h00

// timing counts in converter clock periods
`define ACS_ACQ_DEFAULT  13'd256

`endif

// >>> acs_pkg.sv
package acs_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PRE  = 4'h2,
        ST_ACQ  = 4'h4,
        ST_CONV = 4'h8
    } acs_state_e;

    // drive to the analog sampling front end
    typedef struct packed {
        logic        precharge;
        logic        pre_level;
        logic        guard_level;
        logic        acquire;
        logic        convert;
        logic [15:0] dac_code;
        logic [4:0]  extra_cap;
    } acs_afe_s;

    // register bus request
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acs_bus_s;

    typedef struct packed {
        logic [4:0]  cap;
        logic [12:0] pre;
        logic [12:0] acq;
        logic        on;
        logic        continuous_enable;
        logic        cs;
        logic        result_alignment;
        logic        go;
        logic        precharge_polarity;
        logic        invert_precharge_enable;
        logic        guard_polarity;
        logic        double_sample_enable;
        logic        stop_on_irq;
        logic [7:0]  div;
        logic [7:0]  divcnt;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [15:0] res;
        logic [15:0] prev;
        acs_state_e  st;
        logic [12:0] cnt;
        logic        second;
        logic        stop_req;
        logic [3:0]  bitpos;
        logic [15:0] code;
        logic        tick;
        logic        rc_s1;
        logic        rc_s2;
        logic        rc_s3;
        logic        cmp_s1;
        logic        cmp_s2;
        logic [7:0]  rdata;
        logic        irq;
        logic        compute;
        acs_afe_s    afe;
    } acs_state_s;

endpackage : acs_pkg

// >>> adc_conversion_sequence_control_tb.sv
`timescale 1ns/10ps
`include "acs_defines.svh"
module adc_conversion_sequence_control_tb;
    import acs_pkg::*;

    localparam int RB = 8;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    acs_bus_s    bus     = '0;
    logic [7:0]  reg_rdata;
    acs_afe_s    afe;
    logic        rc_osc_pin;
    logic        cmp_pin;
    logic        thr     = 1'b0;
    logic        rc_en   = 1'b0;
    logic [15:0] target  = 16'h00A5;
    logic        compute_start;
    logic        irq;
    logic        pc_q    = 1'b0;
    logic [1:0]  plv     = 2'b00;
    logic [1:0]  glv     = 2'b00;
    logic [7:0]  d;
    int          fails   = 0;
    int          checks  = 0;
    int          pre_cyc = 0;
    int          acq_cyc = 0;
    int          dones   = 0;

    acs_conv_seq #(.RES_BITS(RB)) dut (
        .sys_clk(sys_clk), .reset(reset), .bus(bus), .reg_rdata(reg_rdata),
        .rc_osc_pin(rc_osc_pin), .cmp_pin(cmp_pin), .afe(afe),
        .threshold_irq_flag(thr), .compute_start(compute_start), .irq(irq));
    acs_afe_model #(.RES_BITS(RB)) afe_model (
        .sys_clk(sys_clk), .rc_en(rc_en), .target(target), .afe(afe),
        .rc_osc_pin(rc_osc_pin), .cmp_pin(cmp_pin));

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    // phase lengths, polarities at each precharge start, completions
    always @(posedge sys_clk)
    begin
        pc_q <= afe.precharge;
        if (afe.precharge) pre_cyc <= pre_cyc + 1;
        if (afe.acquire) acq_cyc <= acq_cyc + 1;
        if (compute_start) dones <= dones + 1;
        if (afe.precharge && !pc_q)
        begin
            plv <= {plv[0], afe.pre_level};
            glv <= {glv[0], afe.guard_level};
        end
    end

    task conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task chk_rng(input int v, input int lo, input int hi);
        checks++;
        if (v < lo || v > hi)
        begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h to %0h", $time, v, lo, hi);
        end
    endtask : chk_rng

    task wr(input logic [8:0] a, input logic [7:0] dat);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task rchk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
        chk(d, exp);
    endtask : rchk

    task wait_done(input int n);
        for (int i = 0; i < 6000 && dones < n; i++) @(posedge sys_clk);
        if (dones < n)
        begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, dones, n);
            conclude();
        end
    endtask : wait_done

    task run(input logic [7:0] con0);
        pre_cyc = 0;
        acq_cyc = 0;
        dones = 0;
        wr(`ACS_ADR_CON0, con0);
        wait_done(1);
    endtask : run

    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        rchk(`ACS_ADR_CAP, 8'h00);
        rchk(`ACS_ADR_PRE_LO, 8'h00);
        rchk(`ACS_ADR_PRE_HI, 8'h00);
        rchk(`ACS_ADR_CON0, 8'h00);
        rchk(`ACS_ADR_CON1, 8'h00);
        rchk(9'h100, 8'h00);
        wr(`ACS_ADR_CAP, 8'hFF);
        rchk(`ACS_ADR_CAP, 8'h1F);
        chk(afe.extra_cap, 5'h1F);
        wr(`ACS_ADR_CAP, 8'h00);
        rchk(`ACS_ADR_CAP, 8'h00);
        chk(afe.extra_cap, 5'h00);
        wr(`ACS_ADR_PRE_HI, 8'hFF);
        rchk(`ACS_ADR_PRE_HI, 8'h1F);
        wr(`ACS_ADR_PRE_HI, 8'h00);
        wr(`ACS_ADR_PRE_LO, 8'h02);
        rchk(`ACS_ADR_PRE_LO, 8'h02);
        wr(`ACS_ADR_DIV, 8'h03);
        wr(`ACS_ADR_CON1, 8'h80);
        wr(`ACS_ADR_CON0, 8'h01);
        rchk(`ACS_ADR_CON0, 8'h00);
        // precharge 2 ticks, acquisition default, 4 cycles a tick
        run(8'h85);
        chk_rng(pre_cyc, 5, 8);
        chk_rng(acq_cyc, 1020, 1028);
        chk(plv[0], 1'b1);
        chk(glv[0], 1'b0);
        rchk(`ACS_ADR_RES_LO, 8'hA5);
        rchk(`ACS_ADR_RES_HI, 8'h00);
        rchk(`ACS_ADR_CON0, 8'h84);
        rchk(`ACS_ADR_STAT, 8'h01);
        chk(irq, 1'b0);
        wr(`ACS_ADR_MASK, 8'h01);
        @(negedge sys_clk);
        chk(irq, 1'b1);
        wr(`ACS_ADR_STAT, 8'h01);
        @(negedge sys_clk);
        chk(irq, 1'b0);
        rchk(`ACS_ADR_STAT, 8'h00);
        // no precharge, left justified, double sample
        wr(`ACS_ADR_PRE_LO, 8'h00);
        wr(`ACS_ADR_ACQ_LO, 8'h03);
        wr(`ACS_ADR_CON1, 8'h01);
        target = 16'h005A;
        run(8'h81);
        chk(pre_cyc, 16'h0000);
        chk_rng(acq_cyc, 21, 24);
        rchk(`ACS_ADR_RES_HI, 8'h5A);
        rchk(`ACS_ADR_RES_LO, 8'h00);
        rchk(`ACS_ADR_PREV_HI, 8'h5A);
        wr(`ACS_ADR_PRE_LO, 8'h01);
        wr(`ACS_ADR_CON1, 8'hE1);
        run(8'h81);
        chk(plv, 2'b10);
        chk(glv, 2'b10);
        wr(`ACS_ADR_CON1, 8'h81);
        run(8'h81);
        chk(plv, 2'b11);
        chk(glv, 2'b00);
        // abort in mid conversion
        wr(`ACS_ADR_CON1, 8'h00);
        wr(`ACS_ADR_STAT, 8'h03);
        target = 16'h00FF;
        dones = 0;
        wr(`ACS_ADR_CON0, 8'h85);
        for (int i = 0; i < 2000 && !afe.convert; i++) @(posedge sys_clk);
        chk(afe.convert, 1'b1);
        repeat (14) @(posedge sys_clk);
        wr(`ACS_ADR_CON0, 8'h84);
        repeat (20) @(posedge sys_clk);
        chk(dones, 16'h0000);
        rchk(`ACS_ADR_STAT, 8'h00);
        rchk(`ACS_ADR_CON0, 8'h84);
        rchk(`ACS_ADR_RES_LO, 8'hF0);
        chk(d[7], 1'b1);
        chk(d == 8'hFF, 1'b0);
        // continuous, stopped by threshold then by software
        target = 16'h00A5;
        wr(`ACS_ADR_PRE_LO, 8'h00);
        wr(`ACS_ADR_ACQ_LO, 8'h01);
        wr(`ACS_ADR_CON3, 8'h01);
        run(8'hC5);
        wait_done(2);
        thr <= 1'b1;
        repeat (150) @(posedge sys_clk);
        thr <= 1'b0;
        rchk(`ACS_ADR_CON0, 8'hC4);
        rchk(`ACS_ADR_STAT, 8'h03);
        wr(`ACS_ADR_CON3, 8'h00);
        run(8'hC5);
        wait_done(3);
        wr(`ACS_ADR_CON0, 8'hC4);
        repeat (60) @(posedge sys_clk);
        rchk(`ACS_ADR_CON0, 8'hC4);
        chk_rng(dones, 3, 4);
        // rc oscillator clock: stalls while it stands still
        dones = 0;
        wr(`ACS_ADR_CON0, 8'h95);
        repeat (100) @(posedge sys_clk);
        rchk(`ACS_ADR_CON0, 8'h95);
        rc_en <= 1'b1;
        wait_done(1);
        rc_en <= 1'b0;
        rchk(`ACS_ADR_RES_LO, 8'hA5);
        conclude();
    end
endmodule : adc_conversion_sequence_control_tb
